//--- core/focp_pkg.sv
// package: register map, field layout, command codes and timing for the flash sequencer
package focp_pkg;
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_IDX = 8'h04;
  localparam logic [7:0] OFS_PHI = 8'h08;
  localparam logic [7:0] OFS_PLO = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_PROT = 8'h14;
  localparam logic [7:0] OFS_RADDR = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1c;
  localparam int ST_COMMAND_COMPLETE_FLAG = 7;
  localparam int ST_ACCESS_ERROR_FLAG = 5;
  localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
  localparam int ST_MG1 = 1;
  localparam int ST_MG0 = 0;
  localparam int CFG_RDONCE_OK = 0;
  localparam int CFG_PGM_OK = 1;
  localparam int CFG_PGMONCE_OK = 2;
  localparam int CFG_RD_FAULT = 3;
  localparam logic [3:0] CFG_RST = 4'h7;
  localparam logic [23:0] PROT_RST = 24'hff_ffff;
  localparam logic [7:0] CMD_RDONCE = 8'h04;
  localparam logic [7:0] CMD_PGM = 8'h06;
  localparam logic [7:0] CMD_PGMONCE = 8'h07;
  localparam logic [2:0] IX_CMD = 3'h0;
  localparam logic [2:0] IX_ADDR_LO = 3'h1;
  localparam logic [2:0] IX_ONE_LW = 3'h3;
  localparam logic [2:0] IX_TWO_LW = 3'h5;
  localparam logic [15:0] PHRASE_MAX = 16'h0007;
  localparam int SLOTS = 6;
  localparam int ONCE_LW = 16;
  localparam logic [23:0] FLASH_BASE_DEF = 24'h00_8000;
  localparam int FLASH_LW_DEF = 256;
  localparam logic [31:0] ERASED = 32'hffff_ffff;
  localparam logic [31:0] INVALID_DATA = 32'hdead_dead;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_NS = 40;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RO = 5'b00010,
    S_BLANK = 5'b00100,
    S_PROG = 5'b01000,
    S_VERIFY = 5'b10000
  } focp_state_t;
endpackage

//--- core/focp_flash_if.sv
// interface: sequencer to flash array connection
interface focp_flash_if #(parameter int AW = 8);
  logic wr;
  logic wr_once;
  logic [AW-1:0] addr;
  logic [3:0] once_addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] once_rdata;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  modport ctrl (output wr, wr_once, addr, once_addr, wdata, rd_addr,
                input rdata, once_rdata, rd_data);
  modport mem (input wr, wr_once, addr, once_addr, wdata, rd_addr,
               output rdata, once_rdata, rd_data);
endinterface

//--- core/focp_array.sv
// flash array: main longwords and the 64-byte write-once field
module focp_array #(
  parameter int LW = 256,
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  focp_flash_if.mem fl
);
  import focp_pkg::*;
  logic [31:0] main_r [LW];
  logic [31:0] once_r [ONCE_LW];

  assign fl.rdata = main_r[fl.addr];
  assign fl.rd_data = main_r[fl.rd_addr];
  assign fl.once_rdata = once_r[fl.once_addr];

  // programming only clears bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LW; i++) main_r[i] <= ERASED;
      for (int j = 0; j < ONCE_LW; j++) once_r[j] <= ERASED;
    end else begin
      if (fl.wr) main_r[fl.addr] <= main_r[fl.addr] & fl.wdata;
      if (fl.wr_once) once_r[fl.once_addr] <= once_r[fl.once_addr] & fl.wdata;
    end
  end
endmodule // focp_array

//--- core/focp_top.sv
// top: apb registers and command sequencer for read-once, program and program-once
// Function
// - 64-byte write-once field, read-once code 0x04
// - phrase index at 001, range 0..7
// - read-once puts phrase into slots 010..101
// - complete flag set only when finished
// - ordinary reads invalid during read-once
// - read-once needs index pointer 001
// - read-once fault sets both verify bits
// - program code 0x06, address and data slots
// - program then read back and compare
// - program needs index 011 or 101
// - program address low bits must be 00
// - words past block end give access error
// - address outside flash map gives error
// - protected target sets protection violation
// - verify mismatch sets both verify bits
// - command not allowed in mode errors
// - program-once blank check, program, verify
// - second program-once refused with error
// - program-once needs index pointer 101
// - ordinary reads invalid during program-once
// - unknown command code gives access error
module focp_top #(
  parameter logic [23:0] FLASH_BASE = focp_pkg::FLASH_BASE_DEF,
  parameter int FLASH_LW = focp_pkg::FLASH_LW_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import focp_pkg::*;
  localparam int AW = $clog2(FLASH_LW);

  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    hit = (a[31:2] == {24'h0, ofs[7:2]});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  focp_state_t state_r;
  logic command_complete_flag_r, access_error_flag_r, protection_violation_flag_r, mg_r;
  logic [2:0] idx_r, idx_hi_r;
  logic [15:0] slot_r [SLOTS];
  logic [3:0] cfg_r;
  logic [23:0] prot_r;
  logic [AW-1:0] raddr_r;
  logic lw_r, two_r, once_r;
  logic [3:0] tmr_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;

  focp_flash_if #(.AW(AW)) fl ();
  focp_array #(.LW(FLASH_LW), .AW(AW)) u_array (
    .pclk(pclk),
    .presetn(presetn),
    .fl(fl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_r;
  wire wr_acc = acc & pwrite;
  wire h_stat = hit(paddr, OFS_STAT);
  wire h_idx = hit(paddr, OFS_IDX);
  wire h_phi = hit(paddr, OFS_PHI);
  wire h_plo = hit(paddr, OFS_PLO);
  wire h_cfg = hit(paddr, OFS_CFG);
  wire h_prot = hit(paddr, OFS_PROT);
  wire h_raddr = hit(paddr, OFS_RADDR);
  wire h_rdata = hit(paddr, OFS_RDATA);
  wire mapped = h_stat | h_idx | h_phi | h_plo | h_cfg | h_prot | h_raddr | h_rdata;
  wire slot_ok = (idx_r < 3'(SLOTS));
  wire slot_wr = wr_acc & command_complete_flag_r & slot_ok & (h_phi | h_plo);

  ////////////////////////////////////////////////////////////////////////////
  // launch checks
  wire [7:0] cmd = slot_r[0][15:8];
  wire [23:0] gaddr = {slot_r[0][7:0], slot_r[1]};
  wire [15:0] phrase = slot_r[1];
  wire is_ro = (cmd == CMD_RDONCE);
  wire is_pg = (cmd == CMD_PGM);
  wire is_po = (cmd == CMD_PGMONCE);
  wire two_lw = (idx_hi_r == IX_TWO_LW);
  wire [24:0] flash_end = {1'b0, FLASH_BASE} + 25'(FLASH_LW * 4);
  wire [24:0] last_e = {1'b0, gaddr} + (two_lw ? 25'h8 : 25'h4);
  wire [23:0] off = gaddr - FLASH_BASE;
  wire in_map = (gaddr >= FLASH_BASE) && ({1'b0, gaddr} < flash_end);
  // group must not pass block end
  wire fits = (last_e <= flash_end);
  wire phrase_bad = (phrase > PHRASE_MAX);
  wire ro_bad = (idx_hi_r != IX_ADDR_LO) | phrase_bad;
  wire pg_idx_bad = (idx_hi_r != IX_ONE_LW) && (idx_hi_r != IX_TWO_LW);
  wire pg_bad = pg_idx_bad | (gaddr[1:0] != 2'b00) | ~in_map | ~fits;
  wire po_bad = (idx_hi_r != IX_TWO_LW) | phrase_bad;
  wire mode_ok = (is_ro & cfg_r[CFG_RDONCE_OK]) | (is_pg & cfg_r[CFG_PGM_OK]) |
                 (is_po & cfg_r[CFG_PGMONCE_OK]);
  wire err_acc = ~(is_ro | is_pg | is_po) | ~mode_ok | (is_ro & ro_bad) |
                 (is_pg & pg_bad) | (is_po & po_bad);
  wire err_prot = ~err_acc & is_pg & (gaddr >= prot_r);
  wire launch = wr_acc & h_stat & pwdata[ST_COMMAND_COMPLETE_FLAG] & command_complete_flag_r & ~access_error_flag_r & ~protection_violation_flag_r;
  wire go = launch & ~err_acc & ~err_prot;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer datapath
  wire [31:0] expect_w = lw_r ? {slot_r[4], slot_r[5]} : {slot_r[2], slot_r[3]};
  wire [31:0] got_w = once_r ? fl.once_rdata : fl.rdata;
  wire prog_end = (tmr_r == 4'(PROG_CYC - 1));
  wire last_lw = (lw_r == two_r);
  wire blank_fail = (state_r == S_BLANK) & (fl.once_rdata != ERASED);
  wire vfy_fail = (state_r == S_VERIFY) & (got_w != expect_w);
  wire ro_fault = (state_r == S_RO) & cfg_r[CFG_RD_FAULT];
  wire done = ((state_r == S_RO) & lw_r) | blank_fail | ((state_r == S_VERIFY) & last_lw);
  assign fl.wr = (state_r == S_PROG) & (tmr_r == 4'h0) & ~once_r;
  assign fl.wr_once = (state_r == S_PROG) & (tmr_r == 4'h0) & once_r;
  assign fl.addr = off[AW+1:2] + AW'(lw_r);
  assign fl.once_addr = {phrase[2:0], lw_r};
  assign fl.wdata = expect_w;
  assign fl.rd_addr = raddr_r;

  ////////////////////////////////////////////////////////////////////////////
  // status flags, hardware set wins over software clear
  wire clr_acc = wr_acc & h_stat & pwdata[ST_ACCESS_ERROR_FLAG];
  wire clr_fpv = wr_acc & h_stat & pwdata[ST_PROTECTION_VIOLATION_FLAG];
  wire set_acc = (launch & err_acc) | blank_fail;
  wire set_mg = vfy_fail | ro_fault;
  wire command_complete_flag_nxt = (command_complete_flag_r & ~go) | done;
  wire access_error_flag_nxt = (access_error_flag_r & ~clr_acc) | set_acc;
  wire protection_violation_flag_nxt = (protection_violation_flag_r & ~clr_fpv) | (launch & err_prot);
  wire mg_nxt = (mg_r & ~go) | set_mg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_complete_flag_r <= 1'b1;
      access_error_flag_r <= 1'b0;
      protection_violation_flag_r <= 1'b0;
      mg_r <= 1'b0;
    end else begin
      command_complete_flag_r <= command_complete_flag_nxt;
      access_error_flag_r <= access_error_flag_nxt;
      protection_violation_flag_r <= protection_violation_flag_nxt;
      mg_r <= mg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      lw_r <= 1'b0;
      two_r <= 1'b0;
      once_r <= 1'b0;
      tmr_r <= 4'h0;
    end else begin
      case (state_r)
        S_IDLE: begin
          lw_r <= 1'b0;
          tmr_r <= 4'h0;
          if (go) begin
            two_r <= two_lw | is_po;
            once_r <= is_po;
            if (is_ro) begin
              state_r <= S_RO;
            end else if (is_pg) begin
              state_r <= S_PROG;
            end else begin
              state_r <= S_BLANK;
            end
          end
        end
        S_RO: begin
          lw_r <= ~lw_r;
          if (lw_r) begin
            state_r <= S_IDLE;
          end
        end
        S_BLANK: begin
          lw_r <= ~lw_r;
          if (blank_fail) begin
            state_r <= S_IDLE;
          end else if (lw_r) begin
            state_r <= S_PROG;
          end
        end
        S_PROG: begin
          tmr_r <= tmr_r + 4'h1;
          if (prog_end) begin
            state_r <= S_VERIFY;
          end
        end
        S_VERIFY: begin
          tmr_r <= 4'h0;
          if (last_lw) begin
            state_r <= S_IDLE;
          end else begin
            lw_r <= 1'b1;
            state_r <= S_PROG;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter slots and config registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLOTS; i++) slot_r[i] <= 16'h0000;
      idx_r <= 3'h0;
      idx_hi_r <= 3'h0;
      cfg_r <= CFG_RST;
      prot_r <= PROT_RST;
      raddr_r <= '0;
    end else begin
      if (wr_acc & h_idx & command_complete_flag_r) idx_r <= pwdata[2:0];
      if (wr_acc & h_cfg) cfg_r <= pwdata[3:0];
      if (wr_acc & h_prot) prot_r <= pwdata[23:0];
      if (wr_acc & h_raddr) raddr_r <= pwdata[AW+1:2];
      if (slot_wr & h_phi) slot_r[idx_r][15:8] <= pwdata[7:0];
      if (slot_wr & h_plo) slot_r[idx_r][7:0] <= pwdata[7:0];
      if (go) begin
        idx_hi_r <= IX_CMD;
      end else if (slot_wr && idx_r > idx_hi_r) begin
        idx_hi_r <= idx_r;
      end
      if (state_r == S_RO) begin
        if (lw_r) begin
          slot_r[4] <= fl.once_rdata[31:16];
          slot_r[5] <= fl.once_rdata[15:0];
        end else begin
          slot_r[2] <= fl.once_rdata[31:16];
          slot_r[3] <= fl.once_rdata[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read path
  wire [7:0] stat_w = {command_complete_flag_r, 1'b0, access_error_flag_r, protection_violation_flag_r, 2'b00, mg_r, mg_r};
  wire [15:0] cur_slot = slot_ok ? slot_r[idx_r] : 16'h0000;
  wire [31:0] flash_rd = command_complete_flag_r ? fl.rd_data : INVALID_DATA;
  wire [31:0] rd_mux = h_stat ? {24'h0, stat_w} :
                       h_idx ? {29'h0, idx_r} :
                       h_phi ? {24'h0, cur_slot[15:8]} :
                       h_plo ? {24'h0, cur_slot[7:0]} :
                       h_cfg ? {28'h0, cfg_r} :
                       h_prot ? {8'h0, prot_r} :
                       h_raddr ? 32'({raddr_r, 2'b00}) :
                       h_rdata ? flash_rd : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup) prdata_r <= pwrite ? 32'h0 : rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_command_complete_flag_busy_low: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r != S_IDLE) |-> !command_complete_flag_r) else $error("complete flag set while busy");
  a_ro_index_err: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && is_ro && idx_hi_r != IX_ADDR_LO) |=> (access_error_flag_r && command_complete_flag_r && state_r == S_IDLE))
    else $error("read-once bad index not refused");
  a_pg_index_err: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && is_pg && idx_hi_r != IX_ONE_LW && idx_hi_r != IX_TWO_LW) |=> access_error_flag_r)
    else $error("program bad index not refused");
  a_pg_align_err: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && is_pg && gaddr[1:0] != 2'b00) |=> (access_error_flag_r && state_r == S_IDLE))
    else $error("misaligned program not refused");
  a_po_index_err: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && is_po && idx_hi_r != IX_TWO_LW) |=> access_error_flag_r)
    else $error("program-once bad index not refused");
  a_unknown_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && !is_ro && !is_pg && !is_po) |=> (access_error_flag_r && command_complete_flag_r))
    else $error("unknown command not refused");
  a_prog_length: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_r == S_PROG) |-> (state_r == S_PROG)[*8] ##1 (state_r == S_VERIFY))
    else $error("program pulse length wrong");
  a_busy_read_bad: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && h_rdata && !command_complete_flag_r) |=> (prdata_r == INVALID_DATA))
    else $error("flash read valid while busy");
  a_prot_viol: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && err_prot) |=> (protection_violation_flag_r && command_complete_flag_r && !fl.wr))
    else $error("protected program not refused");
  a_ro_two_words: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_r == S_RO) |-> !lw_r ##1 (state_r == S_RO && lw_r) ##1 (state_r == S_IDLE && command_complete_flag_r))
    else $error("read-once did not fetch both longwords");
  a_ro_read_bad: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && h_rdata && state_r == S_RO) |=> (prdata_r == INVALID_DATA))
    else $error("flash read valid during read-once");
  a_ro_fault_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == S_RO && cfg_r[CFG_RD_FAULT]) |=> (stat_w[1:0] == 2'b11))
    else $error("read-once fault not flagged");
  a_vfy_both_bits: assert property (@(posedge pclk) disable iff (!presetn)
    vfy_fail |=> (stat_w[1:0] == 2'b11))
    else $error("verify failure not flagged");
  a_po_second_err: assert property (@(posedge pclk) disable iff (!presetn)
    blank_fail |=> (access_error_flag_r && command_complete_flag_r && state_r == S_IDLE))
    else $error("second program-once not refused");
endmodule // focp_top

//--- dv/focp_top_test.sv
// testbench: apb-driven command sequences for the flash sequencer
module focp_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import focp_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int error_cnt;
  int comparisons;
  logic [31:0] rd_v;
  logic err_v;
  ////////////////////////////////////////////////////////////////////////////////
  focp_top i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );
  always #2.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp, $sformatf("read %h", a));
  endtask
  task automatic ld(input logic [2:0] ix, input logic [15:0] w);
    apb(1'b1, OFS_IDX, {29'h0, ix});
    apb(1'b1, OFS_PHI, {24'h0, w[15:8]});
    apb(1'b1, OFS_PLO, {24'h0, w[7:0]});
  endtask
  task automatic slot(input logic [2:0] ix, input logic [15:0] w);
    apb(1'b1, OFS_IDX, {29'h0, ix});
    rchk(OFS_PHI, {24'h0, w[15:8]});
    rchk(OFS_PLO, {24'h0, w[7:0]});
  endtask
  // load slots 0..top, launch, wait for completion, check and clear status
  task automatic run(input logic [15:0] s0, input logic [15:0] s1, input logic [63:0] d,
                     input logic [2:0] top, input logic [7:0] exp, input logic busy);
    int n;
    for (int i = 0; i <= int'(top); i++) begin
      ld(3'(i), i == 0 ? s0 : i == 1 ? s1 : d[63 - 16 * (i - 2) -: 16]);
    end
    apb(1'b1, OFS_STAT, 32'h80);
    if (busy) begin
      rchk(OFS_RDATA, INVALID_DATA);
      if (s0[15:8] != CMD_RDONCE) rchk(OFS_STAT, 32'h0);
    end
    n = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
      n++;
    end while (rd_v[ST_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 100);
    chk(rd_v, {24'h0, exp}, "status");
    apb(1'b1, OFS_STAT, 32'h30);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    test_done;
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_STAT, 32'h80);
    rchk(OFS_CFG, {28'h0, CFG_RST});
    rchk(OFS_PROT, {8'h0, PROT_RST});
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err_v}, 32'h1, "unmapped");
    // launch-time refusals, index pointer rising across the refused launches
    run({CMD_RDONCE, 8'h00}, 16'h0008, 64'h0, 3'd1, 8'ha0, 1'b0);
    run(16'h0500, 16'h0000, 64'h0, 3'd1, 8'ha0, 1'b0);
    apb(1'b1, OFS_CFG, 32'h6);
    run({CMD_RDONCE, 8'h00}, 16'h0000, 64'h0, 3'd1, 8'ha0, 1'b0);
    apb(1'b1, OFS_CFG, 32'h7);
    run({CMD_RDONCE, 8'h00}, 16'h0000, 64'h0, 3'd2, 8'ha0, 1'b0);
    run({CMD_PGMONCE, 8'h00}, 16'h0000, 64'h0, 3'd3, 8'ha0, 1'b0);
    run({CMD_PGM, 8'h00}, 16'h8000, 64'h0, 3'd4, 8'ha0, 1'b0);
    run({CMD_PGM, 8'h00}, 16'h8002, 64'h0, IX_TWO_LW, 8'ha0, 1'b0);
    run({CMD_PGM, 8'h00}, 16'h0000, 64'h0, IX_TWO_LW, 8'ha0, 1'b0);
    run({CMD_PGM, 8'h00}, 16'h83fc, 64'h0, IX_TWO_LW, 8'ha0, 1'b0);
    apb(1'b1, OFS_PROT, 32'h8100);
    run({CMD_PGM, 8'h00}, 16'h8100, 64'h0, IX_TWO_LW, 8'h90, 1'b0);
    apb(1'b1, OFS_PROT, {8'h0, PROT_RST});
    apb(1'b1, OFS_RADDR, 32'h100);
    rchk(OFS_RDATA, ERASED);
    // program two longwords, read back, then a failing reprogram
    run({CMD_PGM, 8'h00}, 16'h8000, 64'h1234_5678_9abc_def0, IX_TWO_LW, 8'h80, 1'b1);
    apb(1'b1, OFS_RADDR, 32'h4);
    rchk(OFS_RDATA, 32'h9abc_def0);
    run({CMD_PGM, 8'h00}, 16'h8000, 64'hffff_ffff_0000_0000, IX_ONE_LW, 8'h83, 1'b0);
    apb(1'b1, OFS_RADDR, 32'h0);
    rchk(OFS_RDATA, 32'h1234_5678);
    // write-once field: program, read back, fault, second write
    run({CMD_PGMONCE, 8'h00}, 16'h0001, 64'ha5a5_5a5a_0f0f_f0f0, IX_TWO_LW, 8'h80, 1'b1);
    run({CMD_RDONCE, 8'h00}, 16'h0001, 64'h0, IX_ADDR_LO, 8'h80, 1'b1);
    slot(3'd2, 16'ha5a5);
    slot(3'd3, 16'h5a5a);
    slot(3'd4, 16'h0f0f);
    slot(3'd5, 16'hf0f0);
    apb(1'b1, OFS_CFG, 32'hf);
    run({CMD_RDONCE, 8'h00}, 16'h0001, 64'h0, IX_ADDR_LO, 8'h83, 1'b0);
    apb(1'b1, OFS_CFG, 32'h7);
    run({CMD_PGMONCE, 8'h00}, 16'h0001, 64'h0, IX_TWO_LW, 8'ha0, 1'b0);
    test_done;
  end
endmodule // focp_top_test
